// ### logic/lmst_params.svh
`ifndef LMST_PARAMS_SVH
`define LMST_PARAMS_SVH

// panel geometry
`define LMST_DOT_COLS 480
`define LMST_DOT_ROWS 64
`define LMST_DOTS_PER_DRIVER 64
`define LMST_PULSES_PER_LINE 120
`define LMST_PULSES_PER_LINE_W 7'h78
`define LMST_FIRST_ECL_PULSES 15

// display memory layout, graphic rows and text page then font
`define LMST_MEM_BYTES 13'h1800
`define LMST_ROW_BYTES 13'h003C
`define LMST_TEXT_COLS 13'h0050
`define LMST_CHAR_WIDTH 9'h006
`define LMST_FONT_BASE 13'h1000
`define LMST_GRAPHIC_RESET 1'b1

// timing
`define LMST_LINE_TIME_US 130
`define LMST_LINK_PERIOD_PS 15000
`define LMST_LINE_CYCLES ((`LMST_LINE_TIME_US * 1000000) / `LMST_LINK_PERIOD_PS)
`define LMST_LATCH_SLOTS 1
`define LMST_FIFO_DEPTH 8

`endif

// ### logic/lmst_pkg.sv
package lmst_pkg;

	typedef struct packed {
		logic frame_start;
		logic line_start;
		logic [3:0] nibble;
	} lmst_word_t;

	typedef enum logic [3:0] {
		lmst_st_wait = 4'h1,
		lmst_st_latch = 4'h2,
		lmst_st_shift = 4'h4,
		lmst_st_fill = 4'h8
	} lmst_state_t;

endpackage

// ### logic/lmst_scan.sv
// Summary of operation
// - drive a panel of 480 dot columns by 64 dot rows
// - graphic mode maps each bit of the first 3840 bytes of memory to one dot
// - character mode takes dot patterns from the font table at 0x1000 in display memory
// - pixel data leaves serially, locked to the generated column and row timing
// - the whole panel is rescanned continuously to hold contrast
// - eight 64-dot column drivers plus one row driver are addressed
// - only one column driver takes data at a time, enable walks the cascade
// - line latch pulse drives the first column driver's enable input
// - chip-enable clock pulses then select drivers two through eight in turn
// - four data bits go out in parallel per shift clock
// - sixteen shift clocks per driver, eight for the last, one nibble per shift clock
// - within a driver, nibbles go out from highest segment downward
// - four dots per shift clock, 120 shift clocks per 480-dot line
// - a whole dot line is shifted out within about 130 us
// - the per-line transfer repeats 64 times per panel
// - each line latch pulse advances the row driver by one line
// - first chip-enable period holds 15 shift clocks, the next six 16, the last 9
`timescale 1ns/1ns
`include "lmst_params.svh"

module lmst_fifo #(
	parameter int WIDTH = 6,
	parameter int DEPTH = `LMST_FIFO_DEPTH
) (
	input wire logic wr_clk,
	input wire logic wr_rst_n,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic rd_clk,
	input wire logic rd_rst_n,
	output logic [WIDTH-1:0] rd_data,
	output logic rd_valid,
	input wire logic rd_ready
);
	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 4 || (1 << AW) != DEPTH || WIDTH < 1)
		begin : g_bad
			$error("lmst_fifo needs a power-of-two depth of at least 4");
		end
	endgenerate

	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW:0] wbin;
	logic [AW:0] wgray;
	logic [AW:0] rbin;
	logic [AW:0] rgray;
	logic [AW:0] rgray_s1;
	logic [AW:0] rgray_s2;
	logic [AW:0] wgray_s1;
	logic [AW:0] wgray_s2;

	wire push = wr_valid & wr_ready;
	wire pop = rd_valid & rd_ready;
	wire [AW:0] next_wbin = wbin + {{AW{1'b0}}, push};
	wire [AW:0] next_wgray = next_wbin ^ (next_wbin >> 1);
	wire [AW:0] next_rbin = rbin + {{AW{1'b0}}, pop};
	wire [AW:0] next_rgray = next_rbin ^ (next_rbin >> 1);

	// gray pointers cross the domains, so only one bit moves per step
	assign wr_ready = wgray != {~rgray_s2[AW:AW-1], rgray_s2[AW-2:0]};
	assign rd_valid = rgray != wgray_s2;
	assign rd_data = mem[rbin[AW-1:0]];

	always_ff @(posedge wr_clk)
	begin
		if (push)
			mem[wbin[AW-1:0]] <= wr_data;
	end

	always_ff @(posedge wr_clk or negedge wr_rst_n)
	begin
		if (!wr_rst_n)
		begin
			wbin <= '0;
			wgray <= '0;
			rgray_s1 <= '0;
			rgray_s2 <= '0;
		end
		else
		begin
			wbin <= next_wbin;
			wgray <= next_wgray;
			rgray_s1 <= rgray;
			rgray_s2 <= rgray_s1;
		end
	end

	always_ff @(posedge rd_clk or negedge rd_rst_n)
	begin
		if (!rd_rst_n)
		begin
			rbin <= '0;
			rgray <= '0;
			wgray_s1 <= '0;
			wgray_s2 <= '0;
		end
		else
		begin
			rbin <= next_rbin;
			rgray <= next_rgray;
			wgray_s1 <= wgray;
			wgray_s2 <= wgray_s1;
		end
	end
endmodule // lmst_fifo

module lmst_scan #(
	parameter int LINE_CYCLES = `LMST_LINE_CYCLES,
	parameter int FIFO_DEPTH = `LMST_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic link_clk,
	input wire logic graphic_mode,
	input wire logic mem_wr,
	input wire logic [12:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output logic line_latch_pulse,
	output logic driver_enable_input,
	output logic column_shift_clock,
	output logic column_chip_enable_clock,
	output logic [3:0] column_nibble,
	output logic row_scan_data_out
);
	// one slot for the latch pulse, then one slot per shift clock
	localparam int SHIFT_PERIOD = LINE_CYCLES / (`LMST_PULSES_PER_LINE + `LMST_LATCH_SLOTS);
	localparam int HALF = SHIFT_PERIOD / 2;
	localparam logic [15:0] SP_LAST = 16'(SHIFT_PERIOD - 1);
	localparam logic [15:0] HALF_L = 16'(HALF);
	localparam logic [15:0] LINE_LAST = 16'(LINE_CYCLES - 1);

	// at_half and at_end must fall on different cycles, so a slot needs three
	generate
		if (SHIFT_PERIOD < 3 || LINE_CYCLES > 65535)
		begin : g_bad
			$error("lmst_scan line length out of range");
		end
	endgenerate

	// display memory: graphic bitmap low, text codes low, font at the top
	logic [7:0] mem [0:`LMST_MEM_BYTES-1];

	always_ff @(posedge clk)
	begin
		if (mem_wr && mem_addr < `LMST_MEM_BYTES)
			mem[mem_addr] <= mem_wdata;
	end

	// producer, system clock
	logic [5:0] row;
	logic [2:0] drv;
	logic [3:0] nib;
	logic [1:0] dot;
	logic [2:0] dot_sr;
	logic graphic;
	logic word_valid;
	lmst_pkg::lmst_word_t word;
	logic fifo_wr_ready;

	wire last_drv = drv == 3'h7;
	// last driver only carries dots 448..479
	wire [3:0] nib_last = last_drv ? 4'h7 : 4'hF;
	wire [9:0] seg_top = {1'b0, drv, 6'h00} + (last_drv ? 10'h01F : 10'h03F);
	wire [9:0] x10 = seg_top - {4'h0, nib, 2'b00} - {8'h00, dot};
	wire [8:0] x = x10[8:0];

	wire [12:0] g_addr = {7'h00, row} * `LMST_ROW_BYTES + {7'h00, x[8:3]};
	wire [7:0] g_byte = mem[g_addr];
	wire g_bit = g_byte[3'h7 - x[2:0]];
	wire [8:0] c_col = x / `LMST_CHAR_WIDTH;
	wire [8:0] c_off = x % `LMST_CHAR_WIDTH;
	wire [12:0] c_addr = {10'h000, row[5:3]} * `LMST_TEXT_COLS + {4'h0, c_col};
	wire [7:0] c_code = mem[c_addr];
	wire [12:0] f_addr = `LMST_FONT_BASE + {2'b00, c_code, row[2:0]};
	wire [7:0] f_byte = mem[f_addr];
	wire c_bit = f_byte[3'h5 - c_off[2:0]];
	wire pix = graphic ? g_bit : c_bit;
	wire nibble_done = !word_valid && dot == 2'h3;
	wire line_head = drv == 3'h0 && nib == 4'h0;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			dot <= 2'h0;
			dot_sr <= 3'h0;
			word_valid <= 1'b0;
			word <= '0;
		end
		else
		begin
			if (word_valid && fifo_wr_ready)
				word_valid <= 1'b0;
			if (!word_valid)
			begin
				dot_sr <= {dot_sr[1:0], pix};
				dot <= dot + 2'h1;
			end
			if (nibble_done)
			begin
				word_valid <= 1'b1;
				word.nibble <= {dot_sr, pix};
				word.line_start <= line_head;
				word.frame_start <= line_head && row == 6'h00;
			end
		end
	end

	// position counters step once per finished nibble
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			row <= 6'h00;
			drv <= 3'h0;
			nib <= 4'h0;
			graphic <= `LMST_GRAPHIC_RESET;
		end
		else if (nibble_done)
		begin
			nib <= (nib == nib_last) ? 4'h0 : nib + 4'h1;
			if (nib == nib_last)
				drv <= drv + 3'h1;
			if (nib == nib_last && last_drv)
				row <= row + 6'h01;
			// mode only changes between frames so no frame is torn
			if (nib == nib_last && last_drv && row == 6'h3F)
				graphic <= graphic_mode;
		end
	end

	// link domain reset, released on the link clock
	logic lrst_s1;
	logic lrst_n;

	always_ff @(posedge link_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			lrst_s1 <= 1'b0;
			lrst_n <= 1'b0;
		end
		else
		begin
			lrst_s1 <= 1'b1;
			lrst_n <= lrst_s1;
		end
	end

	lmst_pkg::lmst_word_t rd_word;
	logic rd_valid;
	logic rd_ready;

	lmst_fifo #(
		.WIDTH($bits(lmst_pkg::lmst_word_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.wr_clk(clk),
		.wr_rst_n(nrst),
		.wr_data(word),
		.wr_valid(word_valid),
		.wr_ready(fifo_wr_ready),
		.rd_clk(link_clk),
		.rd_rst_n(lrst_n),
		.rd_data(rd_word),
		.rd_valid(rd_valid),
		.rd_ready(rd_ready)
	);

	// link side, link clock
	lmst_pkg::lmst_state_t state;
	logic [15:0] phase;
	logic [15:0] line_timer;
	logic [6:0] pulses;

	wire st_wait = state == lmst_pkg::lmst_st_wait;
	wire st_shift = state == lmst_pkg::lmst_st_shift;
	wire st_fill = state == lmst_pkg::lmst_st_fill;
	wire at_half = phase == HALF_L;
	wire at_end = phase == SP_LAST;
	wire starved = st_shift && phase == 16'h0000 && !rd_valid;
	wire take = st_shift && phase == 16'h0000 && rd_valid;
	// stray words after a reset are flushed up to the next line head
	wire drop = st_wait && rd_valid && !rd_word.line_start;
	wire start = st_wait && rd_valid && rd_word.line_start;
	wire [6:0] next_pulses = pulses + 7'h01;
	wire line_done = next_pulses == `LMST_PULSES_PER_LINE_W;
	// handover after pulse 15, 31, .. 111: drivers two to eight
	wire ecl_due = next_pulses[3:0] == 4'hF && !line_done;
	wire line_over = line_timer >= LINE_LAST;

	assign rd_ready = take | drop;
	assign driver_enable_input = line_latch_pulse;

	always_ff @(posedge link_clk or negedge lrst_n)
	begin
		if (!lrst_n)
			line_timer <= 16'h0000;
		else if (start)
			line_timer <= 16'h0000;
		else if (line_timer != 16'hFFFF)
			line_timer <= line_timer + 16'h0001;
	end

	always_ff @(posedge link_clk or negedge lrst_n)
	begin
		if (!lrst_n)
		begin
			state <= lmst_pkg::lmst_st_wait;
			phase <= 16'h0000;
			pulses <= 7'h00;
			line_latch_pulse <= 1'b0;
			row_scan_data_out <= 1'b0;
		end
		else
		begin
			case (state)
				lmst_pkg::lmst_st_wait:
				begin
					phase <= 16'h0000;
					pulses <= 7'h00;
					if (start)
					begin
						state <= lmst_pkg::lmst_st_latch;
						line_latch_pulse <= 1'b1;
						row_scan_data_out <= rd_word.frame_start;
					end
				end
				lmst_pkg::lmst_st_latch:
				begin
					phase <= at_half ? 16'h0000 : phase + 16'h0001;
					if (at_half)
					begin
						line_latch_pulse <= 1'b0;
						row_scan_data_out <= 1'b0;
						state <= lmst_pkg::lmst_st_shift;
					end
				end
				lmst_pkg::lmst_st_shift:
				begin
					if (!starved)
						phase <= at_end ? 16'h0000 : phase + 16'h0001;
					if (at_end)
						pulses <= line_done ? 7'h00 : next_pulses;
					if (at_end && line_done)
						state <= lmst_pkg::lmst_st_fill;
				end
				lmst_pkg::lmst_st_fill:
				begin
					// pad the line to a fixed period, then go again
					if (line_over)
						state <= lmst_pkg::lmst_st_wait;
				end
				default:
					state <= lmst_pkg::lmst_st_wait;
			endcase
		end
	end

	// pin drivers; data changes only while the shift clock is low
	always_ff @(posedge link_clk or negedge lrst_n)
	begin
		if (!lrst_n)
		begin
			column_nibble <= 4'h0;
			column_shift_clock <= 1'b0;
			column_chip_enable_clock <= 1'b0;
		end
		else
		begin
			if (take)
				column_nibble <= rd_word.nibble;
			if (st_shift && at_half)
				column_shift_clock <= 1'b1;
			else if (at_end || !st_shift)
				column_shift_clock <= 1'b0;
			if (st_shift && at_end)
				column_chip_enable_clock <= ecl_due;
			else if ((st_shift && at_half) || st_fill || st_wait)
				column_chip_enable_clock <= 1'b0;
		end
	end

endmodule // lmst_scan

// ### test/lmst_col_drv_model.sv
`timescale 1ns/1ns
module lmst_col_drv_model (
	input wire logic link_clk,
	input wire logic line_latch_pulse,
	input wire logic column_shift_clock,
	input wire logic column_chip_enable_clock,
	input wire logic [3:0] column_nibble,
	input wire logic row_scan_data_out,
	output logic [479:0] dots,
	output int lines,
	output int nsck,
	output int first,
	output int necl,
	output logic rowf
);
	logic [479:0] cur;
	int s = 0;
	int e = 0;
	int f = 0;
	int top;
	logic r = 1'b0;
	logic go = 1'b0;
	logic pl = 1'b0;
	logic ps = 1'b0;
	logic pe = 1'b0;
	initial lines = 0;
	// inputs sampled on the launching edge, so old values are seen
	always @(posedge link_clk)
	begin
		pl <= line_latch_pulse;
		ps <= column_shift_clock;
		pe <= column_chip_enable_clock;
		if (line_latch_pulse && !pl)
		begin
			if (go)
			begin
				dots <= cur;
				nsck <= s;
				first <= f;
				necl <= e;
				rowf <= r;
				lines <= lines + 1;
			end
			go <= 1'b1;
			s <= 0;
			e <= 0;
			r <= row_scan_data_out;
		end
		if (column_chip_enable_clock && !pe)
		begin
			e <= e + 1;
			if (e == 0)
				f <= s;
		end
		if (column_shift_clock && !ps)
		begin
			top = (s / 16 == 7) ? 479 : (s / 16) * 64 + 63;
			for (int j = 0; j < 4; j++)
				cur[top - 4 * (s % 16) - j] <= column_nibble[3 - j];
			s <= s + 1;
		end
	end
endmodule // lmst_col_drv_model

// ### test/lmst_scan_props.sv
`timescale 1ns/1ns
module lmst_scan_props #(
	parameter int LINE_CYCLES = 363
) (
	input wire logic link_clk,
	input wire logic nrst,
	input wire logic line_latch_pulse,
	input wire logic driver_enable_input,
	input wire logic column_shift_clock,
	input wire logic column_chip_enable_clock,
	input wire logic [3:0] column_nibble,
	input wire logic row_scan_data_out
);
	int sck_n;
	int row_n;
	int lc;
	logic seen;
	default clocking @(posedge link_clk); endclocking
	default disable iff (!nrst);
	// shift and cycle counts kept per line, restarted at each latch rise; row count restarts on the row token
	always_ff @(posedge link_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sck_n <= 0;
			row_n <= 0;
			lc <= 0;
			seen <= 1'b0;
		end
		else if ($rose(line_latch_pulse))
		begin
			sck_n <= 0;
			lc <= 1;
			seen <= 1'b1;
			row_n <= row_scan_data_out ? 1 : row_n + 1;
		end
		else
		begin
			lc <= lc + 1;
			if ($rose(column_shift_clock))
				sck_n <= sck_n + 1;
		end
	end
	// widths assume the short line of 363 cycles: three-cycle slots, latch high two
	sequence s_sck_hi;
		column_shift_clock ##1 !column_shift_clock;
	endsequence
	sequence s_lat_hi;
		line_latch_pulse [*2] ##1 !line_latch_pulse;
	endsequence
	property p_en;
		driver_enable_input == line_latch_pulse;
	endproperty
	property p_lat;
		$rose(line_latch_pulse) |-> s_lat_hi;
	endproperty
	property p_sck;
		$rose(column_shift_clock) |-> s_sck_hi;
	endproperty
	property p_nib;
		column_shift_clock |-> $stable(column_nibble) ##1 $stable(column_nibble);
	endproperty
	property p_ecl;
		$rose(column_chip_enable_clock) |-> (sck_n % 16 == 15) && (sck_n <= 111);
	endproperty
	property p_cnt;
		$rose(line_latch_pulse) && seen |-> sck_n == 120;
	endproperty
	property p_row;
		$rose(line_latch_pulse) |-> row_scan_data_out == (!seen || row_n == 64);
	endproperty
	property p_per;
		$rose(line_latch_pulse) && seen |-> lc >= LINE_CYCLES && lc <= LINE_CYCLES + 2;
	endproperty
	a_en: assert property (p_en) else $error("enable differs from latch");
	a_lat: assert property (p_lat) else $error("latch width");
	a_sck: assert property (p_sck) else $error("shift clock width");
	a_nib: assert property (p_nib) else $error("nibble moved");
	a_ecl: assert property (p_ecl) else $error("chip enable place");
	a_cnt: assert property (p_cnt) else $error("shift count");
	a_row: assert property (p_row) else $error("row token");
	a_per: assert property (p_per) else $error("line period");
endmodule // lmst_scan_props

// ### test/lmst_scan_tb.sv
`timescale 1ns/1ns
module lmst_scan_tb;
	logic clk = 1'b0;
	logic link_clk = 1'b0;
	logic nrst = 1'b0;
	logic graphic_mode = 1'b1;
	logic mem_wr = 1'b0;
	logic [12:0] mem_addr = 13'h0000;
	logic [7:0] mem_wdata = 8'h00;
	logic lp, en, sck, ecl, rd;
	logic [3:0] nib;
	logic [479:0] dots;
	logic [479:0] exp;
	logic rowf;
	int lines, nsck, first, necl;
	logic [7:0] mem [0:6143];
	int err_count = 0;
	int checks = 0;
	int seen, t, r;
	always #2 clk = ~clk;
	always
	begin
		#7 link_clk = 1'b1;
		#8 link_clk = 1'b0;
	end
	lmst_scan #(.LINE_CYCLES(363)) dut (.clk(clk), .nrst(nrst), .link_clk(link_clk),
		.graphic_mode(graphic_mode), .mem_wr(mem_wr), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .line_latch_pulse(lp), .driver_enable_input(en),
		.column_shift_clock(sck), .column_chip_enable_clock(ecl),
		.column_nibble(nib), .row_scan_data_out(rd));
	lmst_col_drv_model drv (.link_clk(link_clk), .line_latch_pulse(lp),
		.column_shift_clock(sck), .column_chip_enable_clock(ecl),
		.column_nibble(nib), .row_scan_data_out(rd), .dots(dots), .lines(lines),
		.nsck(nsck), .first(first), .necl(necl), .rowf(rowf));
	task stop_test;
		if (err_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task cmp_v(input logic [479:0] got, input logic [479:0] want);
		checks++;
		if (got !== want)
		begin
			err_count++;
			$display("BAD %0t line data", $time);
		end
	endtask
	task cmp_i(input int got, input int want);
		checks++;
		if (got != want)
		begin
			err_count++;
			$display("BAD %0t count %0d not %0d", $time, got, want);
		end
	endtask
	initial
	begin
		void'($urandom(77906));
		repeat (3) @(posedge link_clk);
		@(posedge clk);
		nrst <= 1'b1;
		// bitmap and text page low, font table from 0x1000 up
		for (int a = 0; a < 6144; a++)
		begin
			mem[a] = 8'($urandom);
			@(posedge clk);
			mem_wr <= 1'b1;
			mem_addr <= a[12:0];
			mem_wdata <= mem[a];
		end
		// out-of-range writes must leave the picture alone
		for (int a = 0; a < 16; a++)
		begin
			@(posedge clk);
			mem_addr <= 13'h1800 + 13'($urandom % 2048);
			mem_wdata <= 8'($urandom);
		end
		@(posedge clk);
		mem_wr <= 1'b0;
		// only taken at the frame wrap, so lines up to 64 stay graphic
		graphic_mode <= 1'b0;
		while (lines < 66)
		begin
			seen = lines;
			t = 0;
			while (lines == seen && t < 4000)
			begin
				@(posedge clk);
				t++;
			end
			if (t >= 4000)
			begin
				err_count++;
				$display("BAD %0t no line", $time);
				stop_test;
			end
			if (lines > 4)
			begin
				r = (lines - 1) % 64;
				for (int x = 0; x < 480; x++)
					if (lines > 64)
						exp[x] = mem[4096 + mem[(r / 8) * 80 + x / 6] * 8 + r % 8][5 - x % 6];
					else
						exp[x] = mem[r * 60 + x / 8][7 - x % 8];
				cmp_v(dots, exp);
				cmp_i(nsck, 120);
				cmp_i(first, 15);
				cmp_i(necl, 7);
				cmp_v({479'h0, rowf}, {479'h0, r == 0});
			end
		end
		stop_test;
	end
endmodule // lmst_scan_tb
bind lmst_scan lmst_scan_props #(.LINE_CYCLES(LINE_CYCLES)) u_props (.link_clk(link_clk),
	.nrst(nrst), .line_latch_pulse(line_latch_pulse),
	.driver_enable_input(driver_enable_input), .column_shift_clock(column_shift_clock),
	.column_chip_enable_clock(column_chip_enable_clock), .column_nibble(column_nibble),
	.row_scan_data_out(row_scan_data_out));
